// ==== src/clk_gen_pmc.sv ====
/*
 * Clock generator and sequencer with an AHB-Lite register slave.
 * Assumes slow, main and PLL clocks arrive as pins far slower than hclk.
 */
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module clk_gen_pmc #(
	parameter int NPCK    = 3,
	parameter int NPERIPH = 32
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               slow_clock,
	input  wire logic               main_clock,
	input  wire logic               pll_clock,
	output logic                    crystal_osc_enable,
	output logic                    main_source_select,
	output logic      [6:0]         pll_divider,
	output logic      [10:0]        pll_multiplier,
	output logic                    master_clock_out,
	output logic      [NPCK-1:0]    programmable_clock_out,
	output logic      [NPERIPH-1:0] peripheral_clock_enable,
	output logic                    pmc_irq
);
	typedef struct packed {
		logic                                ap_wr;
		logic                                ap_rd;
		logic [7:0]                          ap_addr;
		logic [31:0]                         rdata;
		logic                                rdy_out;
		logic                                resp;
		logic                                xt_en;
		logic [7:0]                          xt_time;
		logic [10:0]                         xt_cnt;
		logic                                xt_stable;
		logic                                msel;
		logic                                msel_busy;
		logic [1:0]                          msel_cnt;
		logic                                msel_st;
		logic                                meas_arm;
		logic                                meas_run;
		logic [3:0]                          meas_slow;
		logic [15:0]                         freq;
		logic                                freq_rdy;
		logic [6:0]                          pll_div;
		logic [10:0]                         pll_mul;
		logic [5:0]                          pll_cnt;
		logic [5:0]                          pll_wait;
		logic                                pll_run;
		logic                                lock;
		clk_gen_pkg::clk_src_type            clock_source_select;
		logic [2:0]                          clock_divide_ratio;
		clk_gen_pkg::mck_state_type          ms;
		logic [6:0]                          ms_cnt;
		logic                                mck_rdy;
		logic [6:0]                          mck_div;
		logic                                mck_out;
		clk_gen_pkg::clk_src_type [NPCK-1:0] pck_css;
		logic [NPCK-1:0][2:0]                pck_clock_divide_ratio;
		logic [NPCK-1:0]                     pck_en;
		logic [NPCK-1:0]                     pck_rdy;
		logic [NPCK-1:0][1:0]                pck_wait;
		logic [NPCK-1:0][6:0]                pck_div;
		logic [NPCK-1:0]                     pck_out;
		logic [NPERIPH-1:0]                  pcen;
		logic [16:0]                         imr;
		logic                                irq;
	} state_type;

	state_type   st_r;
	state_type   st_nxt;
	logic [31:0] sr_v;

	clk_sync_if #(.N(3)) sy ();

	clk_edge_sync #(.N(3)) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.raw     ({pll_clock, main_clock, slow_clock}),
		.sy      (sy.src)
	);

	// Returns {output level, next count}; ratio one passes the source level
	function automatic logic [7:0] div_step(input logic e, input logic lvl, input logic [7:0] r,
		input logic [6:0] c);
		logic [6:0] n;
		n = c;
		if (e) begin
			n = ((8'(c) + 8'h01) >= r) ? 7'h00 : c + 7'h01;
		end
		return {(r == 8'h01) ? lvl : (8'(n) < (r >> 1)), n};
	endfunction

	assign sr_v = (32'(st_r.xt_stable) << `SR_XT)
		| (32'(st_r.lock) << `SR_LOCK)
		| (32'(st_r.mck_rdy) << `SR_MCK)
		| (32'(st_r.pck_rdy) << `SR_PCK)
		| (32'(st_r.msel_st) << `SR_MSEL);

	always_comb begin
		logic                     wr;
		logic [7:0]               wa;
		logic [31:0]              wd;
		logic                     s;
		logic [31:0]              rd;
		logic [3:0]               rv;
		logic [3:0]               lv;
		logic [7:0]               ds;
		clk_gen_pkg::clk_src_type es;
		logic                     e;
		wr = st_r.ap_wr;
		wa = st_r.ap_addr;
		wd = hwdata;
		s = sy.rise[0];
		rd = 32'h0000_0000;
		rv = 4'h0;
		lv = 4'h0;
		ds = 8'h00;
		es = clk_gen_pkg::SRC_SLOW;
		e = 1'b0;
		st_nxt = st_r;

		// Zero-wait slave: read data is fetched in the address phase
		unique case (haddr[7:0])
			`A_SCSR: rd = `SCSR_FIXED | (32'(st_r.pck_en) << `SC_PCK);
			`A_PCSR: rd = 32'(st_r.pcen);
			`A_MOR: rd = (32'(st_r.xt_en) << `MOR_XT_EN) | (32'(st_r.xt_time) << `MOR_XT_TIME)
				| (32'(st_r.msel) << `MOR_MSEL);
			`A_MCFR: rd = (32'(st_r.freq_rdy) << `MCFR_RDY) | 32'(st_r.freq);
			`A_PLLR: rd = (32'(st_r.pll_div) << `PLL_DIV) | (32'(st_r.pll_cnt) << `PLL_CNT)
				| (32'(st_r.pll_mul) << `PLL_MUL);
			`A_MCKR: rd = (32'(st_r.clock_source_select) << `MCK_CSS) | (32'(st_r.clock_divide_ratio) << `MCK_CLOCK_DIVIDE_RATIO);
			`A_SR: rd = sr_v;
			`A_IMR: rd = 32'(st_r.imr);
			default: begin
				for (int i = 0; i < NPCK; i++) begin
					if (haddr[7:0] == 8'(`A_PCK0 + 4 * i)) begin
						rd = (32'(st_r.pck_css[i]) << `PCK_CSS) | (32'(st_r.pck_clock_divide_ratio[i]) << `PCK_CLOCK_DIVIDE_RATIO);
					end
				end
			end
		endcase
		st_nxt.ap_wr = hsel & htrans[1] & hready & hwrite;
		st_nxt.ap_rd = hsel & htrans[1] & hready & ~hwrite;
		st_nxt.ap_addr = haddr[7:0];
		if (st_nxt.ap_rd) begin
			st_nxt.rdata = rd;
		end
		st_nxt.rdy_out = 1'b1;
		st_nxt.resp = 1'b0;

		if (st_r.xt_en && !st_r.xt_stable) begin
			if (st_r.xt_cnt == 11'h000) begin
				st_nxt.xt_stable = 1'b1;
			end else if (s) begin
				st_nxt.xt_cnt = st_r.xt_cnt - 11'h001;
			end
		end

		if (st_r.meas_arm && s) begin
			st_nxt.meas_arm = 1'b0;
			st_nxt.meas_run = 1'b1;
			st_nxt.meas_slow = 4'h0;
			st_nxt.freq = 16'h0000;
		end else if (st_r.meas_run) begin
			if (sy.rise[1]) begin
				st_nxt.freq = st_r.freq + 16'h0001;
			end
			if (s) begin
				if (st_r.meas_slow == `MEAS_LAST) begin
					st_nxt.meas_run = 1'b0;
					st_nxt.freq_rdy = 1'b1;
				end else begin
					st_nxt.meas_slow = st_r.meas_slow + 4'h1;
				end
			end
		end

		if (st_r.msel_busy && s) begin
			if (st_r.msel_cnt == 2'h0) begin
				st_nxt.msel_busy = 1'b0;
				st_nxt.msel_st = st_r.msel;
				st_nxt.meas_arm = 1'b1;
				st_nxt.meas_run = 1'b0;
				st_nxt.freq_rdy = 1'b0;
			end else begin
				st_nxt.msel_cnt = st_r.msel_cnt - 2'h1;
			end
		end

		if (st_r.pll_run) begin
			if (st_r.pll_wait == 6'h00) begin
				st_nxt.pll_run = 1'b0;
				st_nxt.lock = (st_r.pll_div != 7'h00) && (st_r.pll_mul != 11'h000);
			end else if (s) begin
				st_nxt.pll_wait = st_r.pll_wait - 6'h01;
			end
		end

		// While the PLL relocks after a PLLR write on the PLL source, the master clock runs from the slow clock
		es = (st_r.ms == clk_gen_pkg::MS_PLLWAIT) ? clk_gen_pkg::SRC_SLOW : st_r.clock_source_select;
		e = sy.rise[es];
		unique case (st_r.ms)
			clk_gen_pkg::MS_RUN: begin
			end
			clk_gen_pkg::MS_SWITCH: begin
				if (e) begin
					if (st_r.ms_cnt <= 7'h01) begin
						st_nxt.ms = clk_gen_pkg::MS_RUN;
						st_nxt.mck_rdy = 1'b1;
					end else begin
						st_nxt.ms_cnt = st_r.ms_cnt - 7'h01;
					end
				end
			end
			clk_gen_pkg::MS_PLLWAIT: begin
				if (st_nxt.lock) begin
					st_nxt.ms = clk_gen_pkg::MS_RUN;
					st_nxt.mck_rdy = 1'b1;
				end
			end
			default: begin
				st_nxt.ms = clk_gen_pkg::MS_RUN;
			end
		endcase
		ds = (st_r.clock_divide_ratio == 3'h7) ? 8'h03 : (8'h01 << st_r.clock_divide_ratio);
		{st_nxt.mck_out, st_nxt.mck_div} = div_step(e, sy.lvl[es], ds, st_r.mck_div);

		rv = {st_nxt.mck_out & ~st_r.mck_out, sy.rise};
		lv = {st_r.mck_out, sy.lvl};
		for (int i = 0; i < NPCK; i++) begin
			if (st_r.pck_en[i] && !st_r.pck_rdy[i]) begin
				if (st_r.pck_wait[i] == 2'h0) begin
					st_nxt.pck_rdy[i] = 1'b1;
				end else if (rv[st_r.pck_css[i]]) begin
					st_nxt.pck_wait[i] = st_r.pck_wait[i] - 2'h1;
				end
			end
			ds = 8'h01 << st_r.pck_clock_divide_ratio[i];
			{st_nxt.pck_out[i], st_nxt.pck_div[i]} = div_step(rv[st_r.pck_css[i]], lv[st_r.pck_css[i]], ds,
				st_r.pck_div[i]);
			st_nxt.pck_out[i] = st_nxt.pck_out[i] & st_r.pck_en[i];
		end

		if (wr) begin
			unique case (wa)
				`A_MOR: begin
					st_nxt.xt_en = wd[`MOR_XT_EN];
					st_nxt.xt_time = wd[`MOR_XT_TIME +: 8];
					if (!wd[`MOR_XT_EN]) begin
						st_nxt.xt_stable = 1'b0;
					end else if (!st_r.xt_en) begin
						st_nxt.xt_stable = 1'b0;
						st_nxt.xt_cnt = 11'(wd[`MOR_XT_TIME +: 8]) << `XT_UNIT_SHIFT;
					end
					if (wd[`MOR_MSEL] != st_r.msel) begin
						st_nxt.msel = wd[`MOR_MSEL];
						st_nxt.msel_busy = 1'b1;
						st_nxt.msel_cnt = `MSEL_SLOW_CYC;
						st_nxt.msel_st = 1'b0;
					end
				end
				`A_MCFR: begin
					st_nxt.meas_arm = 1'b1;
					st_nxt.meas_run = 1'b0;
					st_nxt.freq_rdy = 1'b0;
				end
				`A_PLLR: begin
					st_nxt.pll_div = wd[`PLL_DIV +: 7];
					st_nxt.pll_cnt = wd[`PLL_CNT +: 6];
					st_nxt.pll_mul = wd[`PLL_MUL +: 11];
					st_nxt.pll_wait = wd[`PLL_CNT +: 6];
					st_nxt.pll_run = 1'b1;
					st_nxt.lock = 1'b0;
					if (st_r.clock_source_select == clk_gen_pkg::SRC_PLL) begin
						st_nxt.ms = clk_gen_pkg::MS_PLLWAIT;
						st_nxt.mck_rdy = 1'b0;
					end
				end
				`A_MCKR: begin
					if (wd[`MCK_CSS +: 2] != st_r.clock_source_select || wd[`MCK_CLOCK_DIVIDE_RATIO +: 3] != st_r.clock_divide_ratio) begin
						st_nxt.clock_source_select = clk_gen_pkg::clk_src_type'(wd[`MCK_CSS +: 2]);
						st_nxt.clock_divide_ratio = wd[`MCK_CLOCK_DIVIDE_RATIO +: 3];
						st_nxt.ms = clk_gen_pkg::MS_SWITCH;
						st_nxt.mck_rdy = 1'b0;
						st_nxt.ms_cnt = `MCK_SW_EDGES + ((wd[`MCK_CLOCK_DIVIDE_RATIO +: 3] != 3'h0) ? `MCK_CLOCK_DIVIDE_RATIO_EDGES : 7'h00);
					end
				end
				`A_SCER: begin
					for (int i = 0; i < NPCK; i++) begin
						if (wd[`SC_PCK + i] && !st_r.pck_en[i]) begin
							st_nxt.pck_en[i] = 1'b1;
							st_nxt.pck_rdy[i] = 1'b0;
							st_nxt.pck_wait[i] = `PCK_RDY_EDGES;
						end
					end
				end
				`A_SCDR: begin
					for (int i = 0; i < NPCK; i++) begin
						if (wd[`SC_PCK + i]) begin
							st_nxt.pck_en[i] = 1'b0;
							st_nxt.pck_rdy[i] = 1'b0;
						end
					end
				end
				`A_PCER: st_nxt.pcen = st_r.pcen | wd[NPERIPH-1:0];
				`A_PCDR: st_nxt.pcen = st_r.pcen & ~wd[NPERIPH-1:0];
				`A_IER: st_nxt.imr = st_r.imr | wd[16:0];
				`A_IDR: st_nxt.imr = st_r.imr & ~wd[16:0];
				default: begin
					for (int i = 0; i < NPCK; i++) begin
						if (wa == 8'(`A_PCK0 + 4 * i)) begin
							st_nxt.pck_css[i] = clk_gen_pkg::clk_src_type'(wd[`PCK_CSS +: 2]);
							st_nxt.pck_clock_divide_ratio[i] = wd[`PCK_CLOCK_DIVIDE_RATIO +: 3];
							if (st_r.pck_en[i]) begin
								st_nxt.pck_rdy[i] = 1'b0;
								st_nxt.pck_wait[i] = `PCK_RDY_EDGES;
							end
						end
					end
				end
			endcase
		end
		st_nxt.irq = |(sr_v[16:0] & st_r.imr);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
			st_r.rdy_out <= 1'b1;
			st_r.clock_source_select <= clk_gen_pkg::SRC_MAIN;
			st_r.mck_rdy <= 1'b1;
			st_r.meas_arm <= 1'b1;
			st_r.pll_cnt <= `PLL_CNT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hrdata = st_r.rdata;
	assign hreadyout = st_r.rdy_out;
	assign hresp = st_r.resp;
	assign crystal_osc_enable = st_r.xt_en;
	assign main_source_select = st_r.msel;
	assign pll_divider = st_r.pll_div;
	assign pll_multiplier = st_r.pll_mul;
	assign master_clock_out = st_r.mck_out;
	assign programmable_clock_out = st_r.pck_out;
	assign peripheral_clock_enable = st_r.pcen;
	assign pmc_irq = st_r.irq;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_xt_needs_en: assert property (st_r.xt_stable |-> st_r.xt_en) else $error("crystal stable while off");
	a_msel_status: assert property ($rose(st_r.msel_st) |-> st_r.msel && $past(sy.rise[0]))
		else $error("select status rose without switch");
	a_meas_window: assert property ($rose(st_r.freq_rdy) |-> st_r.meas_slow == 4'hf && !st_r.meas_run)
		else $error("measure ended early");
	a_pll_off: assert property (st_r.lock |-> st_r.pll_div != 7'h00 && st_r.pll_mul != 11'h000)
		else $error("locked with PLL off");
	a_pll_relock: assert property (st_r.ap_wr && st_r.ap_addr == `A_PLLR && hwdata[`PLL_CNT +: 6] != 6'h00
		|=> !st_r.lock [*2])
		else $error("lock held after PLL write");
	a_mck_clear: assert property (st_r.ap_wr && st_r.ap_addr == `A_MCKR && hwdata[1:0] != st_r.clock_source_select
		|=> !st_r.mck_rdy && st_r.ms == clk_gen_pkg::MS_SWITCH) else $error("ready kept on switch");
	a_pll_fallback: assert property (st_r.ms == clk_gen_pkg::MS_PLLWAIT |-> !st_r.mck_rdy throughout !st_r.lock)
		else $error("ready during relock");
	a_pck_disable: assert property (st_r.ap_wr && st_r.ap_addr == `A_SCDR && hwdata[`SC_PCK]
		|=> (!st_r.pck_en[0] && !st_r.pck_rdy[0]) ##1 !st_r.pck_out[0]) else $error("clock still on");
	a_irq_follow: assert property ((|(sr_v[16:0] & st_r.imr)) |=> st_r.irq) else $error("irq missed");

	c_pll_lock: cover property ($rose(st_r.lock));
	c_mck_switch: cover property ($rose(st_r.mck_rdy) && st_r.clock_source_select == clk_gen_pkg::SRC_PLL);
	c_freq_done: cover property ($rose(st_r.freq_rdy));
	c_pck_ready: cover property ($rose(st_r.pck_rdy[0]));
endmodule
`default_nettype wire

// ==== common/pmc_consts.svh ====
/*
 * Register offsets, field positions, reset values and settle counts of the
 * clock generator. Assumes byte addresses within a 256-byte window.
 */
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define A_SCER          8'h00
`define A_SCDR          8'h04
`define A_SCSR          8'h08
`define A_PCER          8'h10
`define A_PCDR          8'h14
`define A_PCSR          8'h18
`define A_MOR           8'h20
`define A_MCFR          8'h24
`define A_PLLR          8'h28
`define A_MCKR          8'h30
`define A_PCK0          8'h40
`define A_IER           8'h60
`define A_IDR           8'h64
`define A_SR            8'h68
`define A_IMR           8'h6c

`define MOR_XT_EN       0
`define MOR_XT_TIME     8
`define MOR_MSEL        24
`define MCFR_RDY        16
`define PLL_DIV         0
`define PLL_CNT         8
`define PLL_MUL         16
`define MCK_CSS         0
`define MCK_CLOCK_DIVIDE_RATIO        4
`define PCK_CSS         0
`define PCK_CLOCK_DIVIDE_RATIO        4
`define SC_PCK          8
`define SR_XT           0
`define SR_LOCK         1
`define SR_MCK          3
`define SR_PCK          8
`define SR_MSEL         16

`define SCSR_FIXED      32'h0000_0001
`define PLL_CNT_RST     6'h3f
`define MEAS_LAST       4'hf
`define XT_UNIT_SHIFT   3
`define MSEL_SLOW_CYC   2'h2
`define MCK_SW_EDGES    7'h04
`define MCK_CLOCK_DIVIDE_RATIO_EDGES  7'h40
`define PCK_RDY_EDGES   2'h2

`endif

// ==== common/clk_gen_pkg.sv ====
/*
 * Types shared by the clock generator.
 * Assumes nothing of its surroundings.
 */
package clk_gen_pkg;
	typedef enum logic [1:0] {MS_RUN = 2'h0, MS_SWITCH = 2'h1, MS_PLLWAIT = 2'h3} mck_state_type;
	typedef enum logic [1:0] {SRC_SLOW = 2'h0, SRC_MAIN = 2'h1, SRC_PLL = 2'h2, SRC_MCK = 2'h3} clk_src_type;
endpackage

// ==== common/clk_sync_if.sv ====
/*
 * Carries filtered levels and rising-edge pulses of sampled clock pins.
 * Assumes both ends run on hclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface clk_sync_if #(parameter int N = 3);
	logic [N-1:0] lvl;
	logic [N-1:0] rise;
	modport src (output lvl, output rise);
	modport dst (input lvl, input rise);
endinterface
`default_nettype wire

// ==== src/clk_edge_sync.sv ====
/*
 * Three-stage sampler for foreign clock pins; a change counts once stages
 * two and three agree. Assumes hclk runs well above the sampled clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module clk_edge_sync #(
	parameter int N = 3
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [N-1:0] raw,
	clk_sync_if.src           sy
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
		logic [N-1:0] rise;
	} sync_state_type;

	sync_state_type st_r;
	sync_state_type st_nxt;

	// Stage one feeds stage two only
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.lvl = (st_r.lvl & (st_r.s2 ^ st_r.s3)) | (st_r.s2 & ~(st_r.s2 ^ st_r.s3));
		st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sy.lvl = st_r.lvl;
	assign sy.rise = st_r.rise;
endmodule
`default_nettype wire

// ==== verif/clock_generator_sequencing_test.sv ====
/*
 * Self-checking bench for the clock generator: register slave, crystal, measure, PLL, master, programmable clocks.
 * Assumes pmc_consts.svh on the include path and the bench acting as sole AHB-Lite master.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module clock_generator_sequencing_test;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        slow_clock = 1'b0;
	logic        main_clock = 1'b0;
	logic        pll_clock = 1'b0;
	logic        crystal_osc_enable;
	logic        main_source_select;
	logic [6:0]  pll_divider;
	logic [10:0] pll_multiplier;
	logic        master_clock_out;
	logic [2:0]  programmable_clock_out;
	logic [31:0] peripheral_clock_enable;
	logic        pmc_irq;
	int          err_count = 0;
	int          checks_done = 0;
	int          ph = 0;
	int          t0;
	logic [31:0] rd;

	always #12.5 hclk = ~hclk;

	// Pin clocks derived from hclk; every level lasts the two agreeing samples the filter needs
	always @(posedge hclk) begin
		ph <= ph + 1;
		if (ph % 8 == 7) slow_clock <= ~slow_clock;
		if (ph % 4 == 3) main_clock <= ~main_clock;
		if (ph % 2 == 1) pll_clock <= ~pll_clock;
	end

	clk_gen_pmc clk_gen_pmc_inst (
		.hclk                    (hclk),
		.hresetn                 (hresetn),
		.hsel                    (hsel),
		.haddr                   (haddr),
		.htrans                  (htrans),
		.hwrite                  (hwrite),
		.hsize                   (hsize),
		.hwdata                  (hwdata),
		.hready                  (hreadyout),
		.hrdata                  (hrdata),
		.hreadyout               (hreadyout),
		.hresp                   (hresp),
		.slow_clock              (slow_clock),
		.main_clock              (main_clock),
		.pll_clock               (pll_clock),
		.crystal_osc_enable      (crystal_osc_enable),
		.main_source_select      (main_source_select),
		.pll_divider             (pll_divider),
		.pll_multiplier          (pll_multiplier),
		.master_clock_out        (master_clock_out),
		.programmable_clock_out  (programmable_clock_out),
		.peripheral_clock_enable (peripheral_clock_enable),
		.pmc_irq                 (pmc_irq)
	);

	task automatic give_verdict();
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	// One single transfer; the wait ends only on hready, the watchdog bounds it
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
		// Let the write edge settle before pins are looked at
		#1;
		t0 = ph;
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] q);
		bus(a, 1'b0, 32'h0, q);
	endtask

	task automatic wait_sr(input int b, input string nm);
		int n;
		logic [31:0] s;
		n = 0;
		do begin
			rdr(`A_SR, s);
			n++;
		end while (s[b] !== 1'b1 && n < 1500);
		chk_bit(nm, 1'b1, s[b]);
	endtask

	task automatic t_reset();
		rdr(`A_SCSR, rd);
		chk_word("scsr reset", 32'h1, rd);
		rdr(`A_MCKR, rd);
		chk_word("mckr reset", 32'h1, rd & 32'h73);
		rdr(`A_PLLR, rd);
		chk_word("pllr reset", 32'h3f00, rd & 32'h07ff_3f7f);
		rdr(`A_PCK0, rd);
		chk_word("pck0 reset", 32'h0, rd & 32'h73);
		rdr(`A_SR, rd);
		chk_word("sr reset", 32'h8, rd & 32'h0001_070b);
		rdr(8'h0c, rd);
		chk_word("unmapped read", 32'h0, rd);
		wr(`A_SCSR, 32'h700);
		rdr(`A_SCSR, rd);
		chk_word("scsr read only", 32'h1, rd);
		chk_word("outputs reset", 32'h0, {pll_divider, pll_multiplier, programmable_clock_out});
		chk_bit("hresp okay", 1'b0, hresp);
	endtask

	task automatic t_crystal();
		wr(`A_MOR, 32'h0000_0101);
		chk_bit("xtal enable pin", 1'b1, crystal_osc_enable);
		rdr(`A_SR, rd);
		chk_bit("xtal stable early", 1'b0, rd[0]);
		wait_sr(0, "xtal stable");
		wr(`A_MOR, 32'h0100_0101);
		chk_bit("main select pin", 1'b1, main_source_select);
		rdr(`A_SR, rd);
		chk_bit("select status early", 1'b0, rd[16]);
		wait_sr(16, "select status");
	endtask

	task automatic t_measure();
		int n;
		n = 0;
		do begin
			rdr(`A_MCFR, rd);
			n++;
		end while (rd[16] !== 1'b1 && n < 500);
		chk_bit("measure ready", 1'b1, rd[16]);
		rdr(`A_MCFR, rd);
		// Main period is 8 hclk, slow is 16: sixteen slow cycles hold about 32 main edges
		chk_bit("measure count", 1'b1, rd[15:0] >= 16'h1e && rd[15:0] <= 16'h22);
		if (rd[15:0] == 16'h0000) wr(`A_MOR, 32'h0000_0101);
	endtask

	task automatic t_pll();
		wr(`A_PLLR, 32'h0003_0401);
		chk_word("pll fields", {25'h0, 7'h01}, {25'h0, pll_divider});
		chk_word("pll mul", 32'h3, {21'h0, pll_multiplier});
		rdr(`A_SR, rd);
		chk_bit("lock dropped", 1'b0, rd[1]);
		wait_sr(1, "lock set");
		chk_bit("settle time", 1'b1, (ph - t0) >= 48 && (ph - t0) <= 100);
		wr(`A_PLLR, 32'h0003_0400);
		repeat (200) @(posedge hclk);
		rdr(`A_SR, rd);
		chk_bit("lock with div zero", 1'b0, rd[1]);
		wr(`A_PLLR, 32'h0003_0401);
		wait_sr(1, "relock");
	endtask

	// Every prescaler code on the main clock; the prescaler adds 64 new-source edges
	task automatic t_master();
		logic [2:0] p;
		logic       q0;
		int         n;
		for (int i = 1; i <= 8; i++) begin
			p = i[2:0];
			wr(`A_MCKR, {25'h0, p, 4'h1});
			rdr(`A_SR, rd);
			chk_bit("mck ready cleared", 1'b0, rd[3]);
			wait_sr(3, "mck ready");
			chk_bit("mck switch time", 1'b1, (p != 3'h0) == ((ph - t0) >= 512));
			rdr(`A_MCKR, rd);
			chk_word("mckr readback", {25'h0, p, 4'h1}, rd & 32'h73);
		end
		wr(`A_MCKR, 32'h11);
		wait_sr(3, "mck clock_divide_ratio first");
		wr(`A_MCKR, 32'h12);
		wait_sr(3, "mck on pll");
		wr(`A_PLLR, 32'h0003_0401);
		rdr(`A_SR, rd);
		chk_word("fallback flags", 32'h0, rd & 32'ha);
		wait_sr(1, "fallback relock");
		rdr(`A_SR, rd);
		chk_bit("mck ready with lock", 1'b1, rd[3]);
		wr(`A_MCKR, 32'h11);
		wait_sr(3, "mck back main");
		// Main divided by two: one rise every 16 hclk
		n = 0;
		q0 = master_clock_out;
		repeat (160) begin
			@(posedge hclk);
			#1;
			if (master_clock_out && !q0) n++;
			q0 = master_clock_out;
		end
		chk_bit("mck pin rate", 1'b1, n >= 9 && n <= 11);
	endtask

	task automatic t_pck();
		for (int i = 0; i < 3; i++) begin
			wr(`A_PCK0 + 8'(4 * i), {25'h0, 3'(i), 2'h0, 2'(i + 1)});
			wr(`A_SCER, 32'h1 << (8 + i));
			rdr(`A_SCSR, rd);
			chk_word("pck enabled", 32'h1 | (32'h1 << (8 + i)), rd);
			wait_sr(8 + i, "pck ready");
			wr(`A_SCDR, 32'h0);
			rdr(`A_SCSR, rd);
			chk_bit("scdr zero ignored", 1'b1, rd[8 + i]);
			wr(`A_SCDR, 32'h1 << (8 + i));
			rdr(`A_SR, rd);
			chk_bit("pck ready cleared", 1'b0, rd[8 + i]);
			rdr(`A_SCSR, rd);
			chk_word("pck disabled", 32'h1, rd);
			repeat (4) @(posedge hclk);
			chk_bit("pck pin off", 1'b0, programmable_clock_out[i]);
		end
	endtask

	task automatic t_periph_irq();
		wr(`A_PCER, 32'h8000_0005);
		wr(`A_PCDR, 32'h0000_0001);
		rdr(`A_PCSR, rd);
		chk_word("pcsr", 32'h8000_0004, rd);
		chk_word("periph pins", 32'h8000_0004, peripheral_clock_enable);
		wr(`A_IER, 32'h8);
		rdr(`A_IMR, rd);
		chk_word("imr", 32'h8, rd);
		repeat (3) @(posedge hclk);
		chk_bit("irq raised", 1'b1, pmc_irq);
		wr(`A_IDR, 32'h8);
		repeat (3) @(posedge hclk);
		chk_bit("irq masked", 1'b0, pmc_irq);
	endtask

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_crystal();
		t_measure();
		t_pll();
		t_master();
		t_pck();
		t_periph_irq();
		give_verdict();
	end

	// Whole sequence needs roughly 6500 cycles; the limit leaves ample margin
	initial begin
		#(25 * 60000);
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
